// ### design/utp_pkg.sv
// shared constants and types for the uart transmit path
package utp_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_HOLD = 8'h00; // transmit_holding, write only
  localparam logic [7:0] OFF_IER = 8'h04; // interrupt_enable (mask)
  localparam logic [7:0] OFF_ISR = 8'h08; // interrupt_status, write one to clear
  localparam logic [7:0] OFF_FCR = 8'h0c; // fifo_control
  localparam logic [7:0] OFF_LCR = 8'h10; // line format
  localparam logic [7:0] OFF_MCR = 8'h14; // modem_control
  localparam logic [7:0] OFF_LSR = 8'h18; // line_status, read only
  localparam logic [7:0] OFF_DLL = 8'h1c; // divisor low byte
  localparam logic [7:0] OFF_DLM = 8'h20; // divisor_high_byte
  localparam logic [7:0] OFF_DLD = 8'h24; // divisor_fraction
  // field positions
  localparam int IER_TX_EMPTY = 1; // transmit-empty enable / status bit
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_TX_FLUSH = 2; // self-clearing transmit fifo reset
  localparam int FCR_BLOCK = 3; // block transfer mode
  localparam int MCR_PRESCALE = 7; // divide input clock by 4
  localparam int LSR_HOLD_EMPTY = 5;
  localparam int LSR_SHIFT_EMPTY = 6;
  // reset values
  localparam logic [7:0] DLL_RST = 8'h01; // divisor resets to one
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] DLD_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h03; // eight data bits, one stop, no parity
  // counts
  localparam int OS_16X = 16; // sampling clocks per bit
  localparam int OS_8X = 8;
  localparam int OS_4X = 4;
  localparam logic [1:0] PRE_DIV4_LAST = 2'h3; // last count of the divide-by-4
  localparam logic [4:0] FRAC_STEP = 5'h10; // one input tick in sixteenths
  localparam int MIN_DATA_BITS = 5;
  // line format carrier, low five bits of the format register
  typedef struct packed {
    logic parity_even; // even when set, odd otherwise
    logic parity_en;
    logic two_stop;
    logic [1:0] word_len; // data bits minus five
  } utp_lcr_t;
endpackage

// ### design/utp_baud.sv
// prescaler, fractional baud divisor and oversampling counter
`timescale 1ns/1ps
`default_nettype none
module utp_baud (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // configuration
  input wire logic prescale4,
  input wire logic [15:0] div_int,
  input wire logic [3:0] div_frac,
  input wire logic [1:0] mode,
  // one pulse per serial bit time
  output logic bit_tick
);
  logic [1:0] pre_r, pre_nxt; // prescaler count
  logic [20:0] acc_r, acc_nxt; // phase accumulator in sixteenths
  logic [3:0] os_r, os_nxt; // sampling clocks within a bit
  logic tick_r, tick_nxt;
  logic [20:0] div16; // divisor in sixteenths
  logic [3:0] os_last; // last sampling count of a bit
  logic pre_tick, samp_tick;

  // next state: prescale, divide, then count sampling clocks
  always_comb begin
    div16 = {1'b0, div_int, div_frac};
    // a zero integer part would tick on every prescaled clock whatever the fraction, so clamp to one
    if (div_int == 16'h0000) begin
      div16 = 21'h000010;
    end
    case (mode)
      2'b00: os_last = 4'(utp_pkg::OS_16X - 1);
      2'b01: os_last = 4'(utp_pkg::OS_8X - 1);
      default: os_last = 4'(utp_pkg::OS_4X - 1);
    endcase
    pre_tick = !prescale4 || (pre_r == utp_pkg::PRE_DIV4_LAST);
    pre_nxt = prescale4 ? pre_r + 2'h1 : 2'h0;
    acc_nxt = acc_r;
    samp_tick = 1'b0;
    if (pre_tick) begin
      // fraction resolves in steps of one sixteenth
      acc_nxt = acc_r + 21'(utp_pkg::FRAC_STEP);
      if (acc_nxt >= div16) begin
        acc_nxt = acc_nxt - div16;
        samp_tick = 1'b1;
      end
    end
    os_nxt = os_r;
    tick_nxt = 1'b0;
    if (samp_tick) begin
      // bit time is 16, 8 or 4 sampling clocks
      if (os_r >= os_last) begin
        os_nxt = 4'h0;
        tick_nxt = 1'b1;
      end else begin
        os_nxt = os_r + 4'h1;
      end
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 2'h0;
      acc_r <= 21'h0;
      os_r <= 4'h0;
      tick_r <= 1'b0;
    end else if (ce) begin
      pre_r <= pre_nxt;
      acc_r <= acc_nxt;
      os_r <= os_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign bit_tick = tick_r;
endmodule // utp_baud
`default_nettype wire

// ### design/utp_tx.sv
// uart transmit path: apb registers, transmit fifo, shifter, interrupt
`timescale 1ns/1ps
`default_nettype none
module utp_tx #(
  parameter int DEPTH = 32, // transmit fifo depth
  parameter int AW = 5 // fifo pointer width
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line and side outputs
  output logic txd,
  output logic irq,
  output logic transmit_ready_n
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} utp_state_t;

  // register bank
  logic [7:0] ier_r, ier_nxt; // interrupt_enable
  logic [7:0] isr_r, isr_nxt; // interrupt_status, sticky
  logic [7:0] fcr_r, fcr_nxt; // fifo_control
  logic [7:0] lcr_r, lcr_nxt; // line format
  logic [7:0] mcr_r, mcr_nxt; // modem_control
  logic [7:0] dll_r, dll_nxt, dlm_r, dlm_nxt, dld_r, dld_nxt; // divisor
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt, rdy_n_r, rdy_n_nxt;
  logic empty_d_r, empty_d_nxt; // last cycle's holding-empty view
  // fifo
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  // shifter
  utp_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt; // tx_shifter
  logic [2:0] bcnt_r, bcnt_nxt; // data bit index
  logic scnt_r, scnt_nxt; // stop bit index
  logic par_r, par_nxt; // parity of the loaded byte
  logic txd_r, txd_nxt;
  // decoded helpers
  utp_pkg::utp_lcr_t lcr;
  logic wr_acc, mapped, push, pop, flush, full, hold_empty, shift_empty, tx_event, bit_tick;
  logic [AW:0] cap;
  logic [2:0] last_bit;
  logic [7:0] line_status, load_byte;

  assign lcr = utp_pkg::utp_lcr_t'(lcr_r[4:0]);
  assign last_bit = 3'(lcr.word_len + 3'(utp_pkg::MIN_DATA_BITS - 1));
  // without the fifo the holding register is a single slot
  assign cap = fcr_r[utp_pkg::FCR_FIFO_EN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign full = (cnt_r >= cap);
  // holding empty: byte moved to shifter, or fifo drained
  assign hold_empty = (cnt_r == '0);
  // shifter empty only when shifter and holding/fifo are both empty
  assign shift_empty = hold_empty && (st_r == TX_IDLE);
  assign line_status = {1'b0, shift_empty, hold_empty, 5'h00};
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign load_byte = mem[rptr_r];
  assign mapped = (paddr <= utp_pkg::OFF_DLD) && (paddr[1:0] == 2'b00);

  // baud generator, advances the shifter once per bit time
  utp_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .prescale4(mcr_r[utp_pkg::MCR_PRESCALE]),
    .div_int({dlm_r, dll_r}),
    .div_frac(dld_r[3:0]),
    .mode(dld_r[5:4]),
    .bit_tick(bit_tick)
  );

  // register bank next state and apb answers
  always_comb begin
    ier_nxt = ier_r;
    fcr_nxt = fcr_r;
    lcr_nxt = lcr_r;
    mcr_nxt = mcr_r;
    dll_nxt = dll_r;
    dlm_nxt = dlm_r;
    dld_nxt = dld_r;
    flush = 1'b0;
    push = 1'b0;
    // answer in the first access cycle; data and error set at setup
    pready_nxt = psel && !penable;
    prdata_nxt = prdata_r;
    // error flag stands only beside its ready pulse
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pslverr_nxt = !mapped;
      prdata_nxt = 32'h0;
      if (!pwrite) begin
        // holding register reads as zero, it is write only
        if (paddr == utp_pkg::OFF_IER) begin
          prdata_nxt = {24'h0, ier_r};
        end else if (paddr == utp_pkg::OFF_ISR) begin
          prdata_nxt = {24'h0, isr_r};
        end else if (paddr == utp_pkg::OFF_FCR) begin
          prdata_nxt = {24'h0, fcr_r};
        end else if (paddr == utp_pkg::OFF_LCR) begin
          prdata_nxt = {24'h0, lcr_r};
        end else if (paddr == utp_pkg::OFF_MCR) begin
          prdata_nxt = {24'h0, mcr_r};
        end else if (paddr == utp_pkg::OFF_LSR) begin
          prdata_nxt = {24'h0, line_status};
        end else if (paddr == utp_pkg::OFF_DLL) begin
          prdata_nxt = {24'h0, dll_r};
        end else if (paddr == utp_pkg::OFF_DLM) begin
          prdata_nxt = {24'h0, dlm_r};
        end else if (paddr == utp_pkg::OFF_DLD) begin
          prdata_nxt = {24'h0, dld_r};
        end
      end
    end
    if (wr_acc) begin
      if (paddr == utp_pkg::OFF_HOLD) begin
        // a write into a full holding area is dropped
        push = !full;
      end else if (paddr == utp_pkg::OFF_IER) begin
        ier_nxt = pwdata[7:0];
      end else if (paddr == utp_pkg::OFF_FCR) begin
        // flush bit self-clears; switching fifo mode also empties it
        fcr_nxt = pwdata[7:0] & ~(8'h01 << utp_pkg::FCR_TX_FLUSH);
        flush = pwdata[utp_pkg::FCR_TX_FLUSH] ||
                (pwdata[utp_pkg::FCR_FIFO_EN] != fcr_r[utp_pkg::FCR_FIFO_EN]);
      end else if (paddr == utp_pkg::OFF_LCR) begin
        lcr_nxt = pwdata[7:0];
      end else if (paddr == utp_pkg::OFF_MCR) begin
        mcr_nxt = pwdata[7:0];
      end else if (paddr == utp_pkg::OFF_DLL) begin
        dll_nxt = pwdata[7:0];
      end else if (paddr == utp_pkg::OFF_DLM) begin
        dlm_nxt = pwdata[7:0];
      end else if (paddr == utp_pkg::OFF_DLD) begin
        dld_nxt = {2'b00, pwdata[5:0]}; // only mode and fraction bits exist
      end
    end
    // transmit-empty event on holding-empty rising, in both modes
    empty_d_nxt = hold_empty;
    tx_event = hold_empty && !empty_d_r;
    isr_nxt = isr_r;
    if (wr_acc && (paddr == utp_pkg::OFF_ISR)) begin
      isr_nxt = isr_r & ~pwdata[7:0];
    end
    // set after clear so a same-cycle event survives
    if (tx_event) begin
      isr_nxt[utp_pkg::IER_TX_EMPTY] = 1'b1;
    end
    irq_nxt = |(isr_nxt & ier_nxt & (8'h01 << utp_pkg::IER_TX_EMPTY));
    // ready pin per mode
    if (!fcr_r[utp_pkg::FCR_FIFO_EN] || !fcr_r[utp_pkg::FCR_BLOCK]) begin
      rdy_n_nxt = !(cnt_nxt == '0);
    end else begin
      rdy_n_nxt = (cnt_nxt >= cap);
    end
  end

  // shifter next state, one step per bit time
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bcnt_nxt = bcnt_r;
    scnt_nxt = scnt_r;
    par_nxt = par_r;
    txd_nxt = txd_r;
    pop = 1'b0;
    if (bit_tick) begin
      case (st_r)
        TX_IDLE: begin
          txd_nxt = 1'b1; // line idles high
          pop = !hold_empty;
        end
        TX_START: begin
          txd_nxt = sh_r[0];
          sh_nxt = {1'b0, sh_r[7:1]};
          bcnt_nxt = 3'h0;
          st_nxt = TX_DATA;
        end
        TX_DATA: begin
          if (bcnt_r == last_bit) begin
            // parity only when enabled
            st_nxt = lcr.parity_en ? TX_PARITY : TX_STOP;
            txd_nxt = lcr.parity_en ? par_r : 1'b1;
            scnt_nxt = 1'b0;
          end else begin
            txd_nxt = sh_r[0];
            sh_nxt = {1'b0, sh_r[7:1]};
            bcnt_nxt = bcnt_r + 3'h1;
          end
        end
        TX_PARITY: begin
          st_nxt = TX_STOP;
          txd_nxt = 1'b1;
          scnt_nxt = 1'b0;
        end
        TX_STOP: begin
          if (scnt_r == lcr.two_stop) begin
            // next byte follows with no idle gap
            pop = !hold_empty;
            st_nxt = TX_IDLE;
          end else begin
            scnt_nxt = 1'b1;
          end
        end
        default: st_nxt = TX_IDLE;
      endcase
    end
    if (pop) begin
      // load starts the frame with its start bit
      sh_nxt = load_byte;
      // shift count kept four bits wide so an eight-bit word does not wrap to zero
      par_nxt = ^(load_byte & ~(8'hff << (4'(last_bit) + 4'h1))) ^ !lcr.parity_even;
      txd_nxt = 1'b0;
      st_nxt = TX_START;
    end
  end

  // fifo pointers and count; flush wins over a push in the same cycle
  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      wptr_nxt = '0;
      rptr_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wptr_nxt = AW'((32'(wptr_r) + 1) % DEPTH);
      end
      if (pop) begin
        rptr_nxt = AW'((32'(rptr_r) + 1) % DEPTH);
      end
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // fifo storage; no reset needed for the data words
  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[wptr_r] <= pwdata[7:0];
    end
  end

  // all control state, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_r <= 8'h00;
      isr_r <= 8'h00;
      fcr_r <= 8'h00;
      lcr_r <= utp_pkg::LCR_RST;
      mcr_r <= 8'h00;
      dll_r <= utp_pkg::DLL_RST;
      dlm_r <= utp_pkg::DLM_RST;
      dld_r <= utp_pkg::DLD_RST;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      rdy_n_r <= 1'b0;
      empty_d_r <= 1'b1;
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
      st_r <= TX_IDLE;
      sh_r <= 8'h00;
      bcnt_r <= 3'h0;
      scnt_r <= 1'b0;
      par_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (ce) begin
      ier_r <= ier_nxt;
      isr_r <= isr_nxt;
      fcr_r <= fcr_nxt;
      lcr_r <= lcr_nxt;
      mcr_r <= mcr_nxt;
      dll_r <= dll_nxt;
      dlm_r <= dlm_nxt;
      dld_r <= dld_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      rdy_n_r <= rdy_n_nxt;
      empty_d_r <= empty_d_nxt;
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bcnt_r <= bcnt_nxt;
      scnt_r <= scnt_nxt;
      par_r <= par_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txd = txd_r;
  assign irq = irq_r;
  assign transmit_ready_n = rdy_n_r;
endmodule // utp_tx
`default_nettype wire

// ### test/utp_tx_props.sv
// assertion checker bound to the uart transmit path ports
`timescale 1ns/1ps
`default_nettype none
module utp_tx_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line and side outputs
  input wire logic txd,
  input wire logic irq,
  input wire logic transmit_ready_n
);
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the answer comes in the first access cycle
  a_setup_answer: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  // ready is a one-cycle pulse
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  // error flag tracks the address map exactly
  a_err_map: assert property (pready |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
    else $error("error flag wrong for address");
  // error only with an answer
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_hold_reads_zero: assert property (
    pready && !pwrite && paddr == utp_pkg::OFF_HOLD |-> prdata == 32'h0)
    else $error("holding register readable");
  // only the low byte carries data
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_mask: assert property (
    pready && pwrite && paddr == utp_pkg::OFF_IER && !pwdata[1] && ce |-> ##2 !irq)
    else $error("interrupt not masked");
  // a bit never lasts under four sample ticks of one clock each
  a_low_min: assert property ($fell(txd) |-> !txd [*4])
    else $error("low bit too short");
  a_high_min: assert property ($rose(txd) |-> txd [*4])
    else $error("high bit too short");
  // a low enable freezes txd, irq and transmit_ready_n
  a_ce_freeze: assert property (!ce |=> $stable({txd, irq, transmit_ready_n}))
    else $error("outputs moved while frozen");
endmodule // utp_tx_props
bind utp_tx utp_tx_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd), .irq(irq),
  .transmit_ready_n(transmit_ready_n));
`default_nettype wire

// ### test/utp_rx_model.sv
// remote serial receiver model: mid-bit sampling, 8 data bits, one stop
`timescale 1ns/1ps
`default_nettype none
module utp_rx_model #(
  parameter int BIT = 16 // pclk cycles per serial bit
) (
  // clock and line
  input wire logic pclk,
  input wire logic presetn,
  input wire logic txd,
  // decoded byte, one-cycle valid, stop fault
  output logic [7:0] rx_byte,
  output logic rx_vld,
  output logic rx_bad
);
  // behavioural receiver; a low line while idle starts a frame
  initial begin
    rx_byte = 8'h00;
    rx_vld = 1'b0;
    rx_bad = 1'b0;
    forever begin
      @(posedge pclk);
      rx_vld <= 1'b0;
      if (presetn && !txd) begin
        // land in the middle of the start bit
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge pclk);
          rx_byte[i] <= txd;
        end
        repeat (BIT) @(posedge pclk);
        rx_bad <= !txd;
        rx_vld <= 1'b1;
      end
    end
  end
endmodule // utp_rx_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the uart transmit path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, txd, irq, transmit_ready_n;
  logic [7:0] rx_byte;
  logic rx_vld, rx_bad;
  logic [31:0] seed = 32'hf37c; // fixed so runs repeat
  logic [31:0] q; // last read data
  logic e; // last error flag
  logic [7:0] b;
  logic [7:0] sent [$];
  logic [7:0] got [$];
  int n_errors = 0;
  int check_count = 0;
  // every mode below gives a 16-cycle bit
  localparam logic [7:0] DLLS [4] = '{8'h01, 8'h02, 8'h04, 8'h01};
  localparam logic [7:0] DLDS [4] = '{8'h00, 8'h10, 8'h20, 8'h20};
  localparam logic [7:0] MCRS [4] = '{8'h00, 8'h00, 8'h00, 8'h80};
  always #20 pclk = ~pclk;
  utp_tx DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .irq(irq), .transmit_ready_n(transmit_ready_n));
  utp_rx_model #(.BIT(16)) u_far (.pclk(pclk), .presetn(presetn), .txd(txd),
    .rx_byte(rx_byte), .rx_vld(rx_vld), .rx_bad(rx_bad));
  // xorshift source, low byte used
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // line status from fifo fill and shifter activity
  function automatic logic [7:0] lsr_exp(input int fill, input logic busy);
    return {1'b0, fill == 0 && !busy, fill == 0, 5'h00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; an idle edge first keeps drives apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll line status until the masked bits are set
  task automatic wait_lsr(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, utp_pkg::OFF_LSR, 32'h0);
      n++;
    end while ((q[7:0] & m) != m && n < 3000);
    if (n >= 3000) n_errors++;
  endtask
  task automatic wait_rx(input int cnt);
    repeat (4000) if (got.size() < cnt) @(posedge pclk);
    check(got.size(), cnt);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // gather decoded bytes from the far end
  always @(posedge pclk) begin
    if (rx_vld === 1'b1) begin
      got.push_back(rx_byte);
      check(rx_bad, 1'b0);
    end
  end
  // hang guard, well past the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] ra [9];
    logic [7:0] rv [9];
    ra = '{utp_pkg::OFF_LSR, utp_pkg::OFF_DLL, utp_pkg::OFF_DLM, utp_pkg::OFF_DLD,
      utp_pkg::OFF_LCR, utp_pkg::OFF_HOLD, utp_pkg::OFF_IER, utp_pkg::OFF_FCR,
      utp_pkg::OFF_MCR};
    rv = '{lsr_exp(0, 1'b0), utp_pkg::DLL_RST, utp_pkg::DLM_RST, utp_pkg::DLD_RST,
      utp_pkg::LCR_RST, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({txd, irq}, 2'b10);
    // reset values, then one unmapped place
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check(q, {24'h0, rv[i]});
      check(e, 1'b0);
    end
    apb(1'b0, 8'h28, 32'h0);
    check({e, q[7:0]}, 9'h100);
    apb(1'b1, utp_pkg::OFF_IER, 32'h2);
    // one byte in each sampling mode and with the prescaler
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, utp_pkg::OFF_DLL, {24'h0, DLLS[m]});
      apb(1'b1, utp_pkg::OFF_DLD, {24'h0, DLDS[m]});
      apb(1'b1, utp_pkg::OFF_MCR, {24'h0, MCRS[m]});
      b = rnd();
      sent.push_back(b);
      apb(1'b1, utp_pkg::OFF_HOLD, {24'h0, b});
      wait_lsr(8'h20);
      repeat (2) @(posedge pclk);
      check(irq, 1'b1);
      apb(1'b1, utp_pkg::OFF_ISR, 32'h2);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
      wait_lsr(8'h40);
      wait_rx(sent.size());
    end
    // masked: status still sets, the interrupt stays low
    apb(1'b1, utp_pkg::OFF_IER, 32'h0);
    b = rnd();
    sent.push_back(b);
    apb(1'b1, utp_pkg::OFF_HOLD, {24'h0, b});
    wait_lsr(8'h60);
    check(irq, 1'b0);
    apb(1'b0, utp_pkg::OFF_ISR, 32'h0);
    check(q[1], 1'b1);
    // fifo with block mode: one byte shifting, 32 waiting
    apb(1'b1, utp_pkg::OFF_IER, 32'h2);
    apb(1'b1, utp_pkg::OFF_FCR, 32'h9);
    for (int i = 0; i < 33; i++) begin
      b = rnd();
      sent.push_back(b);
      apb(1'b1, utp_pkg::OFF_HOLD, {24'h0, b});
    end
    repeat (2) @(posedge pclk);
    check(transmit_ready_n, 1'b1);
    apb(1'b0, utp_pkg::OFF_LSR, 32'h0);
    check(q, {24'h0, lsr_exp(32, 1'b1)});
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b1, utp_pkg::OFF_ISR, 32'h2);
    wait_lsr(8'h20);
    check(q[6], 1'b0);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    check(transmit_ready_n, 1'b0);
    wait_lsr(8'h40);
    wait_rx(sent.size());
    for (int i = 0; i < sent.size(); i++) begin
      check(got[i], sent[i]);
    end
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
